/* verilog/iru_interrupt_request_unit.sv */
// Interrupt request unit: flags, enables, vectoring and return stack
`timescale 1ns/100ps
module iru_interrupt_request_unit
    import iru_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = STACK_LEVELS,
    parameter int unsigned SP_W        = $clog2(STACK_DEPTH)
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    input  wire logic              ext_irq_pin,
    input  wire logic [3:0]        change_watch_pins,
    input  wire logic [7:0]        timer_count,
    input  wire logic              nvm_write_done,
    input  wire iru_core_req_t     core_req,
    output iru_core_rsp_t          core_rsp
);

    localparam int LAT_WIN = LAT_MAX - LAT_MIN;

    logic [7:0]       interrupt_control;
    logic [7:0]       next_interrupt_control;
    logic             nvm_write_done_flag;
    logic             ext_edge_select;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_enable;
    logic             sleeping;
    logic [SP_W-1:0]  sp;
    logic [PC_WIDTH-1:0] stack_top;
    logic [31:0]      rd_mux;
    logic             rd_unmapped;

    logic       ext_s1, ext_s2, ext_prev;
    logic [3:0] watch_s1, watch_s2, watch_prev, watch_diff;
    logic [7:0] timer_prev;
    logic [2:0] sync_fill;
    logic       ext_edge, port_change, timer_roll;
    logic       any_enabled, pending, take, do_return, wake;
    logic       wr_en, wr_intctl;
    logic [EVT_W-1:0] evt;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_s1     <= 1'b0;
            ext_s2     <= 1'b0;
            ext_prev   <= 1'b0;
            watch_s1   <= 4'h0;
            watch_s2   <= 4'h0;
            watch_prev <= 4'h0;
            timer_prev <= TIMER_ZERO;
            sync_fill  <= 3'h0;
        end
        else
        begin
            sync_fill  <= {sync_fill[1:0], 1'b1};
            ext_s1     <= ext_irq_pin;
            ext_s2     <= ext_s1;
            ext_prev   <= ext_s2;
            watch_s1   <= change_watch_pins;
            watch_s2   <= watch_s1;
            watch_prev <= watch_s2;
            timer_prev <= timer_count;
        end
    end

    // per-pin change detect on synchronised samples
    for (genvar i = 0; i < 4; i++)
    begin : g_watch
        assign watch_diff[i] = watch_s2[i] ^ watch_prev[i];
    end

    // edge polarity chosen by edge select
    // detection masked until the chain holds real pin samples
    // reset zeros would otherwise fake an edge on an idle-high pin
    assign ext_edge    = sync_fill[2] &
                         (ext_edge_select ? (ext_s2 & ~ext_prev)
                                          : (~ext_s2 & ext_prev));
    assign port_change = sync_fill[2] & (|watch_diff);
    // rollover seen as maximum followed by zero
    assign timer_roll  = (timer_prev == TIMER_MAX) &&
                         (timer_count == TIMER_ZERO);

    // four sources, each gated by its own enable
    // edge pin term drops out when its enable is clear
    assign any_enabled =
        (interrupt_control[BIT_EXT_FLAG]  & interrupt_control[BIT_EXT_EN])  |
        (interrupt_control[BIT_TMR_FLAG]  & interrupt_control[BIT_TMR_EN])  |
        (interrupt_control[BIT_PORT_FLAG] & interrupt_control[BIT_PORT_EN]) |
        (nvm_write_done_flag              & interrupt_control[BIT_NVM_EN]);
    // global gate over all unmasked sources
    // request formed from flag, enable and global enable
    assign pending   = interrupt_control[BIT_GIE] & any_enabled;
    assign do_return = core_req.return_from_irq_instr;
    // A return in the same cycle wins so the handler is left cleanly
    assign take      = pending & core_req.boundary & ~do_return & ~sleeping;
    // wake needs an enabled flag, not the global enable
    assign wake      = sleeping & any_enabled;

    assign wr_en     = psel & penable & pready & pwrite;
    assign wr_intctl = wr_en && (paddr == OFF_INTCTL);

    always_comb
    begin
        next_interrupt_control = wr_intctl ? pwdata[7:0] : interrupt_control;
        // events set flags regardless of any enable; set beats write
        if (ext_edge)
        begin
            next_interrupt_control[BIT_EXT_FLAG] = 1'b1;
        end
        if (timer_roll)
        begin
            next_interrupt_control[BIT_TMR_FLAG] = 1'b1;
        end
        if (port_change)
        begin
            next_interrupt_control[BIT_PORT_FLAG] = 1'b1;
        end
        if (take)
        begin
            next_interrupt_control[BIT_GIE] = 1'b0;
        end
        else if (do_return)
        begin
            next_interrupt_control[BIT_GIE] = 1'b1;
        end
    end

    // reset clears global enable and all fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_control <= INTCTL_RST;
        end
        else
        begin
            interrupt_control <= next_interrupt_control;
        end
    end

    // write-done flag lives in NVM control; set beats write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nvm_write_done_flag <= NVM_RST;
        end
        else if (nvm_write_done)
        begin
            nvm_write_done_flag <= 1'b1;
        end
        else if (wr_en && (paddr == OFF_NVM))
        begin
            nvm_write_done_flag <= pwdata[BIT_NVM_DONE];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_edge_select <= EDGE_RST;
            irq_enable      <= EVT_RST;
        end
        else
        begin
            if (wr_en && (paddr == OFF_OPTION))
            begin
                ext_edge_select <= pwdata[BIT_EDGE_SEL];
            end
            if (wr_en && (paddr == OFF_ENABLE))
            begin
                irq_enable <= pwdata[EVT_W-1:0];
            end
        end
    end

    // Sticky block events; a new event wins over a clear in the same cycle
    assign evt = {do_return, wake, take};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= EVT_RST;
            irq       <= 1'b0;
        end
        else
        begin
            if (wr_en && (paddr == OFF_CLEAR))
            begin
                irq_status <= (irq_status & ~pwdata[EVT_W-1:0]) | evt;
            end
            else
            begin
                irq_status <= irq_status | evt;
            end
            irq <= |(irq_status & irq_enable);
        end
    end

    // sleep held until an enabled source fires
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleeping <= 1'b0;
        end
        else if (wake)
        begin
            sleeping <= 1'b0;
        end
        else if (core_req.sleep_enter)
        begin
            sleeping <= 1'b1;
        end
    end

    // only the return address is stacked; the stack wraps when full
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sp <= '0;
        end
        else if (take)
        begin
            sp <= SP_W'(sp + 1'b1);
        end
        else if (do_return)
        begin
            sp <= SP_W'(sp - 1'b1);
        end
    end

    iru_stack_mem #(
        .WIDTH   (PC_WIDTH),
        .DEPTH   (STACK_DEPTH),
        .AW      (SP_W)
    ) u_stack (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (take),
        .wr_addr (sp),
        .wr_data (core_req.next_pc),
        .rd_addr (SP_W'(sp - 1'b1)),
        .rd_data (stack_top)
    );

    // push and vector; return reloads the stacked address
    // edge flag next edge, request, then the vector load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_rsp <= '0;
        end
        else
        begin
            core_rsp.load_pc     <= take | do_return;
            core_rsp.pc          <= take ? VECTOR_ADDR : stack_top;
            core_rsp.wake        <= wake;
            core_rsp.irq_pending <= pending;
        end
    end

    always_comb
    begin
        rd_mux      = 32'h0000_0000;
        rd_unmapped = 1'b0;
        unique case (paddr)
            OFF_INTCTL: rd_mux[7:0]          = interrupt_control;
            OFF_NVM:    rd_mux[BIT_NVM_DONE] = nvm_write_done_flag;
            OFF_OPTION: rd_mux[BIT_EDGE_SEL] = ext_edge_select;
            OFF_STATUS: rd_mux[EVT_W-1:0]    = irq_status;
            OFF_CLEAR:  rd_mux               = 32'h0000_0000;
            OFF_ENABLE: rd_mux[EVT_W-1:0]    = irq_enable;
            OFF_CORE:
            begin
                rd_mux[SP_W-1:0]     = sp;
                rd_mux[BIT_SLEEPING] = sleeping;
            end
            default:    rd_unmapped          = 1'b1;
        endcase
    end

    // No wait state: pready is high from the first cycle of the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            pready  <= 1'b1;
            pslverr <= rd_unmapped;
            prdata  <= rd_mux;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    property p_ext_flag;
        @(posedge pclk) disable iff (!presetn)
        (sync_fill[0] && ext_edge_select && $rose(ext_irq_pin))
            ##1 (ext_irq_pin && !wr_intctl)[*3]
            |-> interrupt_control[BIT_EXT_FLAG];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("rising pin edge did not set ext flag");

    property p_gie_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> !interrupt_control[BIT_GIE];
    endproperty
    a_gie_reset: assert property (p_gie_reset)
        else $error("global enable set after reset");

    property p_take;
        @(posedge pclk) disable iff (!presetn)
        take |=> !interrupt_control[BIT_GIE] && core_rsp.load_pc &&
                 (core_rsp.pc == VECTOR_ADDR);
    endproperty
    a_take: assert property (p_take)
        else $error("vector take wrong");

    property p_return;
        @(posedge pclk) disable iff (!presetn)
        core_req.return_from_irq_instr |=> interrupt_control[BIT_GIE] && core_rsp.load_pc;
    endproperty
    a_return: assert property (p_return)
        else $error("return did not re-enable");

    property p_gie_gate;
        @(posedge pclk) disable iff (!presetn)
        (core_rsp.load_pc && core_rsp.pc == VECTOR_ADDR)
            |-> $past(interrupt_control[BIT_GIE]);
    endproperty
    a_gie_gate: assert property (p_gie_gate)
        else $error("vectored with global enable clear");

    property p_latency;
        @(posedge pclk) disable iff (!presetn)
        (ext_edge && interrupt_control[BIT_GIE] &&
         interrupt_control[BIT_EXT_EN] && !sleeping)
            ##1 (core_req.boundary && !core_req.return_from_irq_instr)
            |-> ##[1:LAT_WIN] core_rsp.load_pc;
    endproperty
    a_latency: assert property (p_latency)
        else $error("pin interrupt latency too long");

    property p_timer;
        @(posedge pclk) disable iff (!presetn)
        ($past(timer_count) == TIMER_MAX && timer_count == TIMER_ZERO)
            |=> interrupt_control[BIT_TMR_FLAG];
    endproperty
    a_timer: assert property (p_timer)
        else $error("timer rollover flag missing");

    property p_port;
        @(posedge pclk) disable iff (!presetn)
        (sync_fill[2] && watch_s2 != watch_prev)
            |=> interrupt_control[BIT_PORT_FLAG];
    endproperty
    a_port: assert property (p_port)
        else $error("port change flag missing");

    property p_nvm;
        @(posedge pclk) disable iff (!presetn)
        nvm_write_done |=> nvm_write_done_flag;
    endproperty
    a_nvm: assert property (p_nvm)
        else $error("nvm done flag missing");

    property p_push;
        @(posedge pclk) disable iff (!presetn)
        take ##1 !core_req.return_from_irq_instr |-> ##1
            (stack_top == $past(core_req.next_pc, 2));
    endproperty
    a_push: assert property (p_push)
        else $error("return address not stacked");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        core_rsp.wake |-> $past(any_enabled) && !sleeping;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without enabled source");

    c_take:   cover property (@(posedge pclk) disable iff (!presetn) take);
    c_return: cover property (@(posedge pclk) disable iff (!presetn)
                              take ##[1:20] core_req.return_from_irq_instr);
    c_wake:   cover property (@(posedge pclk) disable iff (!presetn)
                              core_rsp.wake);

endmodule : iru_interrupt_request_unit

/* verilog/iru_pkg.sv */
// Shared constants and carrier types of the interrupt request unit
package iru_pkg;

    // APB register byte offsets
    localparam int unsigned APB_AW     = 8;
    localparam logic [7:0]  OFF_INTCTL = 8'h00;
    localparam logic [7:0]  OFF_NVM    = 8'h04;
    localparam logic [7:0]  OFF_OPTION = 8'h08;
    localparam logic [7:0]  OFF_STATUS = 8'h0C;
    localparam logic [7:0]  OFF_CLEAR  = 8'h10;
    localparam logic [7:0]  OFF_ENABLE = 8'h14;
    localparam logic [7:0]  OFF_CORE   = 8'h18;

    // interrupt_control field positions
    localparam int unsigned BIT_GIE       = 7;
    localparam int unsigned BIT_NVM_EN    = 6;
    localparam int unsigned BIT_TMR_EN    = 5;
    localparam int unsigned BIT_EXT_EN    = 4;
    localparam int unsigned BIT_PORT_EN   = 3;
    localparam int unsigned BIT_TMR_FLAG  = 2;
    localparam int unsigned BIT_EXT_FLAG  = 1;
    localparam int unsigned BIT_PORT_FLAG = 0;
    // nvm_control and option field positions
    localparam int unsigned BIT_NVM_DONE  = 4;
    localparam int unsigned BIT_EDGE_SEL  = 6;
    // core status register field position of the sleep bit
    localparam int unsigned BIT_SLEEPING  = 8;

    // Block event bits in irq_status / irq_enable / irq_clear
    localparam int unsigned EVT_VECTOR = 0;
    localparam int unsigned EVT_WAKE   = 1;
    localparam int unsigned EVT_RETURN = 2;
    localparam int unsigned EVT_W      = 3;

    // Reset values
    localparam logic [7:0]       INTCTL_RST = 8'h00;
    localparam logic             NVM_RST    = 1'b0;
    localparam logic             EDGE_RST   = 1'b1;
    localparam logic [EVT_W-1:0] EVT_RST    = 3'h0;

    // Core side
    localparam int unsigned PC_WIDTH     = 13;
    localparam int unsigned STACK_LEVELS = 8;
    localparam logic [PC_WIDTH-1:0] VECTOR_ADDR = 13'h0004;
    localparam logic [7:0]  TIMER_MAX  = 8'hFF;
    localparam logic [7:0]  TIMER_ZERO = 8'h00;
    // Pin event to vector load, in instruction cycles
    localparam int          LAT_MIN    = 3;
    localparam int          LAT_MAX    = 4;

    typedef struct packed {
        logic                boundary;
        logic                return_from_irq_instr;
        logic                sleep_enter;
        logic [PC_WIDTH-1:0] next_pc;
    } iru_core_req_t;

    typedef struct packed {
        logic                load_pc;
        logic [PC_WIDTH-1:0] pc;
        logic                wake;
        logic                irq_pending;
    } iru_core_rsp_t;

endpackage : iru_pkg

/* verilog/iru_stack_mem.sv */
// Return address stack memory with registered read port
`timescale 1ns/100ps
module iru_stack_mem
#(
    parameter int unsigned WIDTH = 13,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = $clog2(DEPTH)
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read is registered; an entry written on one edge is seen one edge later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : iru_stack_mem

/* testbench/iru_core_model.sv */
// Processor core stand-in: fetch counter, return and sleep pulses
`timescale 1ns/100ps
module iru_core_model
    import iru_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           do_ret,
    input  wire logic           do_sleep,
    input  wire iru_core_rsp_t  core_rsp,
    output iru_core_req_t       core_req,
    output logic [PC_WIDTH-1:0] ret_expect,
    output int                  load_cnt,
    output int                  wake_cnt
);
    logic [PC_WIDTH-1:0] fetch_pc;
    logic [PC_WIDTH-1:0] offered_pc;
    logic                ret_q;
    logic                sleep_q;

    // only the fetch address is offered
    assign core_req = '{boundary: 1'b1, return_from_irq_instr: ret_q,
                        sleep_enter: sleep_q, next_pc: fetch_pc};

    // Fetch runs every cycle so each take pushes a fresh address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch_pc   <= 13'h0100;
            offered_pc <= 13'h0100;
            ret_expect <= 13'h0000;
            ret_q      <= 1'b0;
            sleep_q    <= 1'b0;
            load_cnt   <= 0;
            wake_cnt   <= 0;
        end
        else
        begin
            ret_q      <= do_ret;
            sleep_q    <= do_sleep;
            offered_pc <= fetch_pc;
            fetch_pc   <= core_rsp.load_pc ? core_rsp.pc : fetch_pc + 13'h0001;
            if (core_rsp.load_pc)
                load_cnt <= load_cnt + 1;
            if (core_rsp.wake)
                wake_cnt <= wake_cnt + 1;
            if (core_rsp.load_pc && core_rsp.pc == VECTOR_ADDR)
                ret_expect <= offered_pc;
        end
    end
endmodule : iru_core_model

/* testbench/tb_top.sv */
// Self-checking bench of the interrupt request unit
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("unexpected at %0t: got %h want %h", $time, got, exp); \
        end \
    end
module tb_top
    import iru_pkg::*;
;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [APB_AW-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    logic                ext_irq_pin;
    logic [3:0]          change_watch_pins;
    logic [7:0]          timer_count;
    logic                nvm_write_done;
    logic                do_ret;
    logic                do_sleep;
    iru_core_req_t       core_req;
    iru_core_rsp_t       core_rsp;
    logic [PC_WIDTH-1:0] ret_expect;
    logic [PC_WIDTH-1:0] pcv;
    logic [31:0]         rdv;
    logic                err;
    int                  load_cnt;
    int                  wake_cnt;
    int                  error_cnt;
    int                  check_count;
    int                  n;
    int                  l0;
    int                  w0;

    iru_interrupt_request_unit uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .ext_irq_pin(ext_irq_pin),
        .change_watch_pins(change_watch_pins), .timer_count(timer_count),
        .nvm_write_done(nvm_write_done), .core_req(core_req),
        .core_rsp(core_rsp));

    iru_core_model core (.pclk(pclk), .presetn(presetn), .do_ret(do_ret),
        .do_sleep(do_sleep), .core_rsp(core_rsp), .core_req(core_req),
        .ret_expect(ret_expect), .load_cnt(load_cnt), .wake_cnt(wake_cnt));

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc

    // Request held until the rising edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        `CHK(k < 20, 1'b1)
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h00000000, d, e);
        `CHK(d, exp)
        `CHK(e, 1'b0)
    endtask : rd_chk

    task automatic wait_load(output int k, output logic [PC_WIDTH-1:0] p);
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
            @(negedge pclk);
        end
        while (core_rsp.load_pc !== 1'b1 && k < 12);
        p = core_rsp.pc;
        `CHK(k < 12, 1'b1)
        if (p == VECTOR_ADDR)
            `CHK(core_rsp.irq_pending, 1'b1)
        @(posedge pclk);
    endtask : wait_load

    // Pin held well past one cycle, then flags cleared by software
    task automatic pin_step(input logic v, input logic exp);
        logic [31:0] d;
        logic        e;
        ext_irq_pin <= v;
        cyc(5);
        apb(1'b0, OFF_INTCTL, 32'h00000000, d, e);
        `CHK(d[BIT_EXT_FLAG], exp)
        wr(OFF_INTCTL, 32'h00000000);
    endtask : pin_step

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        close_out();
    end

    initial
    begin
        error_cnt = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        ext_irq_pin = 1'b1;
        change_watch_pins = 4'h0;
        timer_count = 8'h00;
        nvm_write_done = 1'b0;
        do_ret = 1'b0;
        do_sleep = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFF_INTCTL, 32'h00000000);
        rd_chk(OFF_OPTION, 32'h00000040);
        rd_chk(OFF_STATUS, 32'h00000000);
        apb(1'b1, 8'h1C, 32'hFFFFFFFF, rdv, err);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h1C, 32'h00000000, rdv, err);
        `CHK({err, rdv}, 33'h100000000)
        timer_count <= 8'hFF;
        cyc(1);
        timer_count <= 8'h00;
        cyc(3);
        rd_chk(OFF_INTCTL, 32'h00000004);
        wr(OFF_INTCTL, 32'h00000000);
        // the change is held for several cycles
        change_watch_pins <= 4'h8;
        cyc(4);
        rd_chk(OFF_INTCTL, 32'h00000001);
        wr(OFF_INTCTL, 32'h00000000);
        cyc(4);
        rd_chk(OFF_INTCTL, 32'h00000000);
        nvm_write_done <= 1'b1;
        cyc(1);
        nvm_write_done <= 1'b0;
        cyc(2);
        rd_chk(OFF_NVM, 32'h00000010);
        wr(OFF_NVM, 32'h00000000);
        pin_step(1'b0, 1'b0);
        pin_step(1'b1, 1'b1);
        wr(OFF_OPTION, 32'h00000000);
        pin_step(1'b0, 1'b1);
        pin_step(1'b1, 1'b0);
        wr(OFF_OPTION, 32'h00000040);
        wr(OFF_ENABLE, 32'h00000001);
        rd_chk(OFF_ENABLE, 32'h00000001);
        wr(OFF_INTCTL, 32'h00000090);
        ext_irq_pin <= 1'b0;
        cyc(5);
        ext_irq_pin <= 1'b1;
        wait_load(n, pcv);
        `CHK(n inside {3, 4}, 1'b1)
        `CHK(pcv, VECTOR_ADDR)
        rd_chk(OFF_INTCTL, 32'h00000012);
        rd_chk(OFF_STATUS, 32'h00000001);
        `CHK(irq, 1'b1)
        wr(OFF_ENABLE, 32'h00000000);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(OFF_CLEAR, 32'h00000001);
        rd_chk(OFF_STATUS, 32'h00000000);
        wr(OFF_INTCTL, 32'h00000010);
        do_ret <= 1'b1;
        cyc(1);
        do_ret <= 1'b0;
        wait_load(n, pcv);
        `CHK(pcv, ret_expect)
        rd_chk(OFF_INTCTL, 32'h00000090);
        rd_chk(OFF_STATUS, 32'h00000004);
        l0 = load_cnt;
        wr(OFF_INTCTL, 32'h00000082);
        cyc(6);
        `CHK(load_cnt, l0)
        wr(OFF_INTCTL, 32'h00000012);
        cyc(6);
        `CHK(load_cnt, l0)
        `CHK(core_rsp.irq_pending, 1'b0)
        wr(OFF_INTCTL, 32'h000000A0);
        timer_count <= 8'hFF;
        cyc(1);
        timer_count <= 8'h00;
        wait_load(n, pcv);
        `CHK(pcv, VECTOR_ADDR)
        wr(OFF_INTCTL, 32'h00000000);
        w0 = wake_cnt;
        l0 = load_cnt;
        do_sleep <= 1'b1;
        cyc(1);
        do_sleep <= 1'b0;
        ext_irq_pin <= 1'b0;
        cyc(3);
        ext_irq_pin <= 1'b1;
        cyc(6);
        `CHK(wake_cnt, w0)
        rd_chk(OFF_CORE, 32'h00000101);
        wr(OFF_INTCTL, 32'h00000012);
        cyc(4);
        `CHK(wake_cnt, w0 + 1)
        `CHK(load_cnt, l0)
        rd_chk(OFF_CORE, 32'h00000001);
        rd_chk(OFF_STATUS, 32'h00000007);
        close_out();
    end
endmodule : tb_top
